// >>> shared/dmac_params.svh
// Constants for the two-channel cycle-steal transfer controller
`ifndef DMAC_PARAMS_SVH
`define DMAC_PARAMS_SVH
// ****************************************
// Address space and excluded region
// ****************************************
`define DMAC_AW 20
`define DMAC_EXCL_LO 20'h00020
`define DMAC_EXCL_HI 20'h0003f
`define DMAC_STEP_WORD 20'h00002
`define DMAC_STEP_BYTE 20'h00001
// ****************************************
// Cause select codes
// ****************************************
`define DMAC_CODE_PIN 4'h0
`define DMAC_CODE_SW 4'h1
`define DMAC_CODE_BOTH 4'h6
`define DMAC_CODE_ALT_LO 4'h7
`define DMAC_CODE_ALT_HI 4'h9
// ****************************************
// Reset values, counter constants and byte mask
// ****************************************
`define DMAC_ADDR_RST 20'h00000
`define DMAC_CNT_RST 16'h0000
`define DMAC_CNT_ZERO 16'h0000
`define DMAC_CNT_ONE 16'h0001
`define DMAC_DATA_RST 16'h0000
`define DMAC_BYTE_MASK 16'h00ff
`endif

// >>> shared/dmac_pkg.sv
// Types shared by the transfer controller modules
package dmac_pkg;
  // ****************************************
  // Per-channel software controls and status
  // ****************************************
  typedef struct packed {
    logic [3:0] cause_select_field;
    logic cause_expansion_bit;
    logic unit_word;
    logic src_fwd;
    logic dst_fwd;
    logic repeat_mode;
  } dmac_cfg_s;

  typedef struct packed {
    logic en_we;
    logic en_val;
    logic sw_req;
    logic src_we;
    logic dst_we;
    logic rld_we;
    logic [19:0] data;
  } dmac_wr_s;

  typedef struct packed {
    logic en;
    logic sw_req_rd;
    logic [19:0] src_rd;
    logic [19:0] dst_rd;
    logic [15:0] cnt_rd;
    logic [15:0] rld_rd;
  } dmac_stat_s;

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {
    DMAC_IDLE,
    DMAC_LOAD,
    DMAC_RD,
    DMAC_WR
  } dmac_fsm_e;

  typedef struct packed {
    logic en;
    logic first;
    logic pend;
    logic [19:0] src;
    logic [19:0] dst;
    logic [19:0] fwd;
    logic [15:0] cnt;
    logic [15:0] rld;
  } dmac_chan_s;

  typedef struct packed {
    dmac_chan_s [1:0] ch;
    dmac_fsm_e fsm;
    logic cur;
    logic word;
    logic [19:0] addr;
    logic [15:0] data;
    logic [1:0] done;
  } dmac_st_s;

  typedef struct packed {
    logic pin_prev;
  } dmac_sel_st_s;
endpackage : dmac_pkg

// >>> design/dmac_req_sel.sv
// Request cause selector for one transfer channel
`timescale 1ns/10ps
`include "dmac_params.svh"
module dmac_req_sel (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Cause selection
  input wire logic [3:0] cause_select_field,
  input wire logic cause_expansion_bit,
  // Sources
  input wire logic ext_irq_pin,
  input wire logic [15:0] periph_irq,
  input wire logic [15:0] periph_alt_irq,
  input wire logic sw_req,
  // Request out
  output logic req
);
  dmac_pkg::dmac_sel_st_s st_reg;
  dmac_pkg::dmac_sel_st_s st_next;
  logic fall;
  logic rise;

  always_comb begin
    st_next = st_reg;
    st_next.pin_prev = ext_irq_pin;
    fall = st_reg.pin_prev & ~ext_irq_pin;
    rise = ~st_reg.pin_prev & ext_irq_pin;
    // Pin edge pulses and raw source levels, never masked by core interrupt flags
    case (cause_select_field)
      `DMAC_CODE_PIN: req = fall; // RL10 RL21
      `DMAC_CODE_SW: req = sw_req; // RL3 RL20 RL21
      default: begin
        if (cause_expansion_bit && cause_select_field == `DMAC_CODE_BOTH) begin
          req = fall | rise; // RL22
        end else if (cause_expansion_bit && cause_select_field >= `DMAC_CODE_ALT_LO
                     && cause_select_field <= `DMAC_CODE_ALT_HI) begin
          req = periph_alt_irq[cause_select_field]; // RL22
        end else begin
          req = periph_irq[cause_select_field]; // RL3 RL4 RL10
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      // Seeded from the pin so a high idle level gives no false edge after release
      st_reg.pin_prev <= ext_irq_pin;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : dmac_req_sel

// >>> design/dmac_core.sv
// Two-channel cycle-steal transfer controller
`timescale 1ns/10ps
`include "dmac_params.svh"
// Contract
// RL1: Two independent channels steal bus cycles, always above the core in priority.
// RL2: Each serviced request moves exactly one byte or one 16-bit word.
// RL3: Requests come from the software request bit or a chosen peripheral line.
// RL4: Requests ignore core interrupt masks; transfers never touch interrupt state.
// RL5: Enabled channel starts one transfer per request; disabled channel ignores requests.
// RL6: Requests arriving while one is pending merge into one transfer.
// RL7: Any-to-fixed, fixed-to-any and fixed-to-fixed over a 1 MB space.
// RL8: The controller's own register region is never accessed by transfers.
// RL9: Sixteen-bit unit counter: 128K bytes of words or 64K bytes.
// RL10: Causes: pin falling or both edges, timers, serial, converter, software.
// RL11: Simultaneous requests: channel zero first, channel one waits.
// RL12: Source and destination each forward or fixed, never both forward.
// RL13: Single mode: counter underflow clears enable, channel goes inactive.
// RL14: Repeat mode: underflow reloads counter; stays active until enable written 0.
// RL15: Every counter underflow raises the channel's transfer-complete pulse.
// RL16: First transfer after activation loads forward pointer and counter first.
// RL17: Forward pointer writable always; fixed pointers only while disabled.
// RL18: All readable; while enabled the forward register reads the working pointer.
// RL19: Each unit decrements counter by one and advances forward address by unit.
// RL20: Software request bit write of 1 requests once; it reads back 0.
// RL21: Four-bit cause field: 0000 pin falling edge, 0001 software trigger.
// RL22: Expansion bit remaps codes to both pin edges and extra timers.
module dmac_core (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Request sources
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  input wire logic [15:0] periph_irq,
  input wire logic [15:0] periph_alt_irq,
  // Channel controls, index 0 is channel_zero
  input wire dmac_pkg::dmac_cfg_s [1:0] cfg,
  input wire dmac_pkg::dmac_wr_s [1:0] wr,
  output dmac_pkg::dmac_stat_s [1:0] stat,
  output logic [1:0] done_irq,
  // System bus master
  output logic bus_req,
  output logic bus_we,
  output logic bus_word,
  output logic [19:0] bus_addr,
  output logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_ack
);
  dmac_pkg::dmac_st_s st_reg;
  dmac_pkg::dmac_st_s st_next;
  logic [1:0] req;
  logic excl;

  // ****************************************
  // Request selection per channel
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sel
      dmac_req_sel u_sel (
        .mclk(mclk),
        .rst_n(rst_n),
        .cause_select_field(cfg[gi].cause_select_field),
        .cause_expansion_bit(cfg[gi].cause_expansion_bit),
        .ext_irq_pin(gi == 0 ? ext_irq_pin_a : ext_irq_pin_b), // RL10
        .periph_irq(periph_irq),
        .periph_alt_irq(periph_alt_irq),
        .sw_req(wr[gi].sw_req),
        .req(req[gi])
      );
    end
  endgenerate

  // ****************************************
  // Helpers
  // ****************************************
  // Both-forward is illegal; should it happen the source wins
  function automatic logic dst_is_fwd(input dmac_pkg::dmac_cfg_s c);
    dst_is_fwd = c.dst_fwd & ~c.src_fwd; // RL12
  endfunction : dst_is_fwd

  function automatic logic [19:0] step_of(input logic w);
    step_of = w ? `DMAC_STEP_WORD : `DMAC_STEP_BYTE; // RL2 RL19
  endfunction : step_of

  // Register region of this block is skipped, never driven on the bus
  assign excl = st_reg.addr >= `DMAC_EXCL_LO && st_reg.addr <= `DMAC_EXCL_HI; // RL8

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic c;
    dmac_pkg::dmac_cfg_s cc;
    dmac_pkg::dmac_chan_s ch;
    c = st_reg.cur;
    cc = cfg[st_reg.cur];
    ch = st_reg.ch[st_reg.cur];
    st_next = st_reg;
    st_next.done = '0;
    case (st_reg.fsm)
      dmac_pkg::DMAC_IDLE: begin
        // Channel zero checked first
        if (st_reg.ch[0].pend && st_reg.ch[0].en) begin // RL11
          c = 1'b0;
        end else begin
          c = 1'b1;
        end
        cc = cfg[c];
        ch = st_reg.ch[c];
        if (ch.pend && ch.en) begin // RL5
          st_next.cur = c;
          st_next.word = cc.unit_word; // RL2
          st_next.ch[c].pend = 1'b0;
          if (ch.first) begin
            st_next.fsm = dmac_pkg::DMAC_LOAD; // RL16
          end else begin
            st_next.addr = cc.src_fwd ? ch.fwd : ch.src; // RL7
            st_next.fsm = dmac_pkg::DMAC_RD; // RL1
          end
        end
      end
      dmac_pkg::DMAC_LOAD: begin
        // Read address is the source reg either way, so it is known now
        st_next.ch[c].fwd = dst_is_fwd(cc) ? ch.dst : ch.src; // RL16
        st_next.ch[c].cnt = ch.rld; // RL16
        st_next.ch[c].first = 1'b0;
        st_next.addr = ch.src;
        st_next.fsm = dmac_pkg::DMAC_RD;
      end
      dmac_pkg::DMAC_RD: begin
        if (excl || bus_ack) begin
          st_next.data = excl ? `DMAC_DATA_RST
                       : (st_reg.word ? bus_rdata : bus_rdata & `DMAC_BYTE_MASK); // RL2 RL8
          st_next.addr = dst_is_fwd(cc) ? ch.fwd : ch.dst; // RL7
          st_next.fsm = dmac_pkg::DMAC_WR;
        end
      end
      dmac_pkg::DMAC_WR: begin
        if (excl || bus_ack) begin
          if (cc.src_fwd || cc.dst_fwd) begin
            st_next.ch[c].fwd = ch.fwd + step_of(st_reg.word); // RL19
          end
          if (ch.cnt == `DMAC_CNT_ZERO) begin
            st_next.done[c] = 1'b1; // RL15
            if (cc.repeat_mode) begin
              st_next.ch[c].cnt = ch.rld; // RL14
            end else begin
              st_next.ch[c].en = 1'b0; // RL13
            end
          end else begin
            st_next.ch[c].cnt = ch.cnt - `DMAC_CNT_ONE; // RL9 RL19
          end
          st_next.fsm = dmac_pkg::DMAC_IDLE;
        end
      end
      default: begin
        st_next.fsm = dmac_pkg::DMAC_IDLE;
      end
    endcase
    // Software writes and request capture come last so a set beats a clear
    for (int i = 0; i < 2; i++) begin
      if (wr[i].en_we) begin
        st_next.ch[i].en = wr[i].en_val; // RL5 RL14
        if (wr[i].en_val && !st_reg.ch[i].en) begin
          st_next.ch[i].first = 1'b1; // RL16
          st_next.ch[i].pend = 1'b0;
        end
      end
      if (wr[i].src_we && (cfg[i].src_fwd || !st_reg.ch[i].en)) begin
        st_next.ch[i].src = wr[i].data; // RL17
      end
      if (wr[i].dst_we && (dst_is_fwd(cfg[i]) || !st_reg.ch[i].en)) begin
        st_next.ch[i].dst = wr[i].data; // RL17
      end
      if (wr[i].rld_we) begin
        st_next.ch[i].rld = wr[i].data[15:0];
      end
      // Later requests merge into the pending flag
      if (req[i] && st_reg.ch[i].en) begin
        st_next.ch[i].pend = 1'b1; // RL4 RL5 RL6
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Request is a level; the arbiter gives it precedence over the core
  assign bus_req = (st_reg.fsm == dmac_pkg::DMAC_RD || st_reg.fsm == dmac_pkg::DMAC_WR) && !excl; // RL1 RL8
  assign bus_we = st_reg.fsm == dmac_pkg::DMAC_WR;
  assign bus_word = st_reg.word;
  assign bus_addr = st_reg.addr;
  assign bus_wdata = st_reg.data;
  assign done_irq = st_reg.done;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_stat
      assign stat[gi].en = st_reg.ch[gi].en;
      assign stat[gi].sw_req_rd = 1'b0; // RL20
      assign stat[gi].src_rd = (st_reg.ch[gi].en && cfg[gi].src_fwd)
                             ? st_reg.ch[gi].fwd : st_reg.ch[gi].src; // RL18
      assign stat[gi].dst_rd = (st_reg.ch[gi].en && dst_is_fwd(cfg[gi]))
                             ? st_reg.ch[gi].fwd : st_reg.ch[gi].dst; // RL18
      assign stat[gi].cnt_rd = st_reg.ch[gi].cnt;
      assign stat[gi].rld_rd = st_reg.ch[gi].rld;
    end
  endgenerate
endmodule : dmac_core

// >>> bench/dmac_core_assertions.sv
// Port-level assertions for the two-channel transfer controller
`timescale 1ns/10ps
`include "dmac_params.svh"
module dmac_core_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Request sources
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  input wire logic [15:0] periph_irq,
  input wire logic [15:0] periph_alt_irq,
  // Channel controls
  input wire dmac_pkg::dmac_cfg_s [1:0] cfg,
  input wire dmac_pkg::dmac_wr_s [1:0] wr,
  input wire dmac_pkg::dmac_stat_s [1:0] stat,
  input wire logic [1:0] done_irq,
  // System bus
  input wire logic bus_req,
  input wire logic bus_we,
  input wire logic bus_word,
  input wire logic [19:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_ack
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  own_region_a: assert property (bus_req |-> (bus_addr < `DMAC_EXCL_LO || bus_addr > `DMAC_EXCL_HI))
    else $error("bus touched own region");
  phase_hold_a: assert property (bus_req && !bus_ack |=> bus_req && $stable(bus_addr) && $stable(bus_we))
    else $error("bus phase dropped before ack");
  read_then_write_a: assert property (bus_req && !bus_we && bus_ack |=> bus_we)
    else $error("read not followed by write");
  byte_upper_a: assert property (bus_req && bus_we && !bus_word |-> bus_wdata[15:8] == 8'h00)
    else $error("byte write upper half not zero");
  sw_read_zero_a: assert property (stat[0].sw_req_rd == 1'b0 && stat[1].sw_req_rd == 1'b0)
    else $error("software request bit read as one");
  idle_ignore_a: assert property ((!stat[0].en && !stat[1].en) [*3] |-> !$rose(bus_req))
    else $error("disabled channels started a transfer");
  done_after_write_a: assert property (done_irq != 2'b00 |-> $past(bus_we) && $onehot(done_irq))
    else $error("done pulse without write phase");
  single_stop_a: assert property (done_irq[0] && !cfg[0].repeat_mode |-> ##[0:1] !stat[0].en)
    else $error("single mode stayed enabled");
  repeat_reload_a: assert property (done_irq[1] && cfg[1].repeat_mode
    |-> ##[0:1] (stat[1].en && stat[1].cnt_rd == stat[1].rld_rd))
    else $error("repeat mode did not reload");
endmodule : dmac_core_chk
bind dmac_core dmac_core_chk u_chk (.mclk(mclk), .rst_n(rst_n), .ext_irq_pin_a(ext_irq_pin_a),
  .ext_irq_pin_b(ext_irq_pin_b), .periph_irq(periph_irq), .periph_alt_irq(periph_alt_irq), .cfg(cfg),
  .wr(wr), .stat(stat), .done_irq(done_irq), .bus_req(bus_req), .bus_we(bus_we), .bus_word(bus_word),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack));

// >>> bench/dmac_bus_model.sv
// Memory-side responder on the shared system bus
`timescale 1ns/10ps
module dmac_bus_model (
  // Clock and pacing
  input wire logic mclk,
  input wire logic slow,
  // Bus from the controller
  input wire logic bus_req,
  input wire logic [19:0] bus_addr,
  // Answer
  output logic [15:0] bus_rdata,
  output logic bus_ack
);
  logic [1:0] dly;
  initial begin
    dly = 2'h0;
    bus_ack = 1'b0;
    bus_rdata = 16'h0000;
  end
  // Slow mode holds off the next ack for two cycles after each ack
  always @(negedge mclk) begin
    if (bus_req && dly == 2'h0) begin
      bus_ack <= 1'b1;
      bus_rdata <= bus_addr[15:0] ^ 16'h5a3c;
      dly <= slow ? 2'h2 : 2'h0;
    end else begin
      bus_ack <= 1'b0;
      bus_rdata <= ~bus_rdata; // Stale data never looks valid
      if (dly != 2'h0) dly <= dly - 2'h1;
    end
  end
endmodule : dmac_bus_model

// >>> bench/two_channel_cycle_steal_dma_tb_top.sv
// Self-checking bench for the two-channel transfer controller
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module two_channel_cycle_steal_dma_tb_top;
  localparam logic [5:0] EN = 6'h30, DIS = 6'h20, SW = 6'h08, SRC = 6'h04, DST = 6'h02, RLD = 6'h01;
  logic mclk, rst_n, pin_a, pin_b, slow, bus_req, bus_we, bus_word, bus_ack, w, lw;
  logic [15:0] pirq, palt, bus_wdata, bus_rdata, ld;
  logic [19:0] bus_addr, la, src, dst, a;
  logic [1:0] done_irq;
  dmac_pkg::dmac_cfg_s [1:0] cfg;
  dmac_pkg::dmac_wr_s [1:0] wr;
  dmac_pkg::dmac_stat_s [1:0] stat;
  logic [19:0] rq[$];
  int mismatches, checks, nw, nd0, nd1, seed, n, i, k, b, e, d;
  int codes[6] = '{1, 0, 6, 2, 7, 10};
  int xs[6] = '{0, 0, 1, 0, 1, 0};
  int ex[6] = '{2, 1, 2, 2, 2, 2};
  dmac_core DUT (.mclk(mclk), .rst_n(rst_n), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b), .periph_irq(pirq),
    .periph_alt_irq(palt), .cfg(cfg), .wr(wr), .stat(stat), .done_irq(done_irq), .bus_req(bus_req),
    .bus_we(bus_we), .bus_word(bus_word), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_ack(bus_ack));
  dmac_bus_model u_mem (.mclk(mclk), .slow(slow), .bus_req(bus_req), .bus_addr(bus_addr), .bus_rdata(bus_rdata),
    .bus_ack(bus_ack));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (bus_req && bus_ack && bus_we) begin
      nw++;
      la = bus_addr;
      ld = bus_wdata;
      lw = bus_word;
    end
    if (bus_req && bus_ack && !bus_we) rq.push_back(bus_addr);
    nd0 += done_irq[0];
    nd1 += done_irq[1];
  end
  task stop_test;
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task wrt(input int c, input logic [5:0] f, input logic [19:0] v);
    @(negedge mclk);
    wr[c] = {f, v};
    @(negedge mclk);
    wr[c] = '0;
  endtask : wrt
  task waitw(input int t);
    int c;
    c = 0;
    while (nw < t && c < 300) begin
      @(negedge mclk);
      c++;
    end
    if (nw < t) mismatches++;
    repeat (2) @(negedge mclk);
  endtask : waitw
  task setup(input int c, input dmac_pkg::dmac_cfg_s f, input logic [19:0] s, input logic [19:0] t,
    input logic [15:0] r);
    @(negedge mclk);
    cfg[c] = f;
    wrt(c, SRC, s);
    wrt(c, DST, t);
    wrt(c, RLD, {4'h0, r});
    wrt(c, EN, 20'h00000);
  endtask : setup
  // Hang guard, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    stop_test();
  end
  initial begin
    seed = 50728;
    {mismatches, checks, nw, nd0, nd1} = '0;
    cfg = '0;
    wr = '0;
    {pin_a, pin_b, pirq, palt, slow, rst_n} = {2'b11, 32'h0, 2'b00};
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    for (i = 0; i < 4; i++) begin
      w = $random(seed);
      n = $random(seed) & 3;
      slow = $random(seed);
      src = 20'h10000 | (20'($random(seed)) & 20'h0fffe);
      dst = 20'h00400 | 20'(2 * i);
      d = nd0;
      setup(0, {4'h1, 1'b0, w, 3'b100}, src, dst, 16'(n));
      wrt(0, DST, 20'h00600);
      `CHK(stat[0].dst_rd, dst)
      for (k = 0; k <= n; k++) begin
        e = nw;
        a = src + 20'(w ? 2 * k : k);
        wrt(0, SW, 20'h00000);
        waitw(e + 1);
        `CHK(rq[rq.size() - 1], a)
        `CHK(la, dst)
        `CHK({lw, ld}, {w, (a[15:0] ^ 16'h5a3c) & (w ? 16'hffff : 16'h00ff)})
        `CHK(stat[0].en, k < n)
        if (k < n) `CHK({stat[0].src_rd, stat[0].cnt_rd}, {a + (w ? 20'h2 : 20'h1), 16'(n - k - 1)})
      end
      `CHK(nd0, d + 1)
    end
    e = nw;
    wrt(0, SW, 20'h00000);
    repeat (10) @(negedge mclk);
    `CHK(nw, e)
    setup(0, {4'h1, 1'b0, 1'b1, 3'b100}, 20'h10000, 20'h00020, 16'h0000);
    wrt(0, SW, 20'h00000);
    repeat (10) @(negedge mclk);
    `CHK({nw, stat[0].en}, {e, 1'b0})
    setup(0, {4'h1, 1'b0, 1'b1, 3'b100}, 20'h20000, 20'h00500, 16'h0000);
    setup(1, {4'h1, 1'b0, 1'b1, 3'b100}, 20'h30000, 20'h00502, 16'h0000);
    e = nw;
    b = rq.size();
    @(negedge mclk);
    wr[0] = {SW, 20'h00000};
    wr[1] = {SW, 20'h00000};
    @(negedge mclk);
    wr = '0;
    waitw(e + 2);
    `CHK({rq[b], rq[b + 1]}, {20'h20000, 20'h30000})
    d = nd1;
    setup(1, {4'h1, 1'b0, 1'b1, 3'b011}, 20'h00700, 20'h40000, 16'h0001);
    for (i = 0; i < 6; i++) begin
      cfg[1].cause_select_field = 4'(codes[i]);
      cfg[1].cause_expansion_bit = xs[i][0];
      e = nw;
      repeat (2) begin
        @(negedge mclk);
        case (codes[i])
          1: wr[1].sw_req = 1'b1;
          0, 6: pin_b = ~pin_b;
          7: palt[7] = 1'b1;
          default: pirq[codes[i]] = 1'b1;
        endcase
        @(negedge mclk);
        {wr, pirq, palt} = '0;
        repeat (12) @(negedge mclk);
      end
      `CHK(nw, e + ex[i])
    end
    `CHK({stat[1].en, stat[1].cnt_rd, stat[1].dst_rd, nd1}, {1'b1, 16'h0000, 20'h40016, d + 5})
    `CHK(stat[1].rld_rd, 16'h0001)
    wrt(1, DST, 20'h41000);
    wrt(1, SRC, 20'h00710);
    wrt(1, DIS, 20'h00000);
    `CHK({stat[1].en, stat[1].dst_rd, stat[1].src_rd}, {1'b0, 20'h41000, 20'h00700})
    e = nw;
    setup(0, {4'h0, 1'b0, 1'b0, 3'b000}, 20'h00800, 20'h00900, 16'h0000);
    @(negedge mclk);
    pin_a = 1'b0;
    repeat (14) @(negedge mclk);
    `CHK({nw, la, ld, lw, stat[0].en}, {e + 1, 20'h00900, (16'h0800 ^ 16'h5a3c) & 16'h00ff, 1'b0, 1'b0})
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    `CHK({stat, done_irq, bus_req}, '0)
    stop_test();
  end
endmodule : two_channel_cycle_steal_dma_tb_top
